// ==== inc/glsup_pkg.sv ====
// Shared constants and types for the guard lock supervisor
package glsup_pkg;

  // Clock rate and derived timing
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned TICK_US          = 1000;              // Timer base period in us (1 ms)
  localparam int unsigned TICK_CYCLES      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TIME_W           = 16;                // Width of delay settings in ms ticks
  localparam int unsigned MAX_INST_SMALL   = 4;                 // Instances on the smaller master
  localparam int unsigned MAX_INST_LARGE   = 8;                 // Instances on the larger master

  // Default settings in ms
  localparam logic [15:0] RELEASE_MS_DEF   = 16'h0000;
  localparam logic [15:0] FBK_MS_DEF       = 16'h000A;

  // Supervisor states
  typedef enum logic [2:0] {
    GLSUP_LOCKED,
    GLSUP_WAIT_RELEASE,
    GLSUP_UNLOCKED,
    GLSUP_WAIT_CLOSE,
    GLSUP_FAULT
  } glsup_state_type;

endpackage : glsup_pkg

// ==== rtl/glsup_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module glsup_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : glsup_sync

// ==== rtl/glsup_top.sv ====
// Guard lock supervisor: magnet drive, feedback watchdog and safe output
`timescale 1ns/1ps
// How it works
// - Safe output high only locked, gate closed.
// - Unlock request drops safe output at once.
// - Magnet releases after configured release delay.
// - Configurable feedback timeout bounds feedback lag.
// - Any error forces safe output low.
// - Fault flag high on error when enabled.
// - Magnet drive alone controls the electromagnet.
// - Feedback reports actual magnet energised state.
// - Gate mode samples gate as door closed.
// - Request, gate, feedback mismatch is error.
// - No-gate mode ignores the gate input.
// - No-gate mode relocks without added delay.
// - Safe output rises once feedback confirms lock.
// - Spring interlock setting fixes drive polarity.
// - At most 4 or 8 instances.
// - Gate mode relocks only after door closes.
module glsup_top #(
  parameter int unsigned TICK_CYCLES = glsup_pkg::TICK_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic                         unlock_req,
  input  wire logic                         magnet_fbk,
  input  wire logic                         gate_closed,
  input  wire logic                         gate_absent,
  input  wire logic                         spring_interlock,
  input  wire logic                         fault_enable,
  input  wire logic                         fault_clear,
  input  wire logic [glsup_pkg::TIME_W-1:0] release_ms,
  input  wire logic [glsup_pkg::TIME_W-1:0] fbk_timeout_ms,
  output logic                              safe_out,
  output logic                              magnet_drive,
  output logic                              fault_flag,
  output logic                              locked_status
);

  localparam int unsigned TW = glsup_pkg::TIME_W;
  localparam int unsigned DW = $clog2(TICK_CYCLES + 1);

  // Unlock, feedback and gate pins pass two flops before use; fault_clear and the static setting straps are used directly
  logic [2:0] pins_s;
  logic       unlock_s;
  logic       fbk_s;
  logic       gate_s;

  glsup_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({unlock_req, magnet_fbk, gate_closed}),
    .dout  (pins_s)
  );

  assign unlock_s = pins_s[2];
  assign fbk_s    = pins_s[1];
  assign gate_s   = pins_s[0];

  glsup_pkg::glsup_state_type state_r;
  glsup_pkg::glsup_state_type state_nxt;
  logic [DW-1:0] div_r;
  logic          tick;
  logic [TW-1:0] rel_cnt_r;
  logic [TW-1:0] fbk_cnt_r;
  logic          energise_r;
  logic          energise_prev_r;
  logic          fbk_pending_r;
  logic          fbk_timeout;
  logic          energised;
  logic          gate_ok;
  logic          mismatch;
  logic          error_r;

  // Millisecond tick from the system clock
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      div_r <= '0;
    else if (div_r == DW'(TICK_CYCLES - 1))
      div_r <= '0;
    else
      div_r <= div_r + DW'(1);
  end

  assign tick = (div_r == DW'(TICK_CYCLES - 1));

  // Feedback is taken as the magnet's true energised level
  assign energised = fbk_s;
  // Gate ignored when absent
  assign gate_ok   = gate_absent | gate_s;

  // Locked magnet with open door, or feedback disagreeing after settling.
  // The cycle right after a drive change is skipped: the watchdog only arms one edge later,
  // and without the skip every drive change would look like a stale feedback.
  assign fbk_timeout = fbk_pending_r && tick && (fbk_cnt_r >= fbk_timeout_ms);
  assign mismatch    = (!gate_absent && !gate_s && state_r == glsup_pkg::GLSUP_LOCKED)
                     || (!fbk_pending_r && energise_r == energise_prev_r
                         && energised != energise_r);

  // Supervisor sequence
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      glsup_pkg::GLSUP_LOCKED:
        if (unlock_s)
          state_nxt = glsup_pkg::GLSUP_WAIT_RELEASE;
      glsup_pkg::GLSUP_WAIT_RELEASE:
        if (!unlock_s)
          state_nxt = glsup_pkg::GLSUP_LOCKED;
        else if (rel_cnt_r >= release_ms)
          state_nxt = glsup_pkg::GLSUP_UNLOCKED;
      glsup_pkg::GLSUP_UNLOCKED:
        if (!unlock_s)
          state_nxt = gate_absent ? glsup_pkg::GLSUP_LOCKED
                                  : glsup_pkg::GLSUP_WAIT_CLOSE;
      glsup_pkg::GLSUP_WAIT_CLOSE:
        if (unlock_s)
          state_nxt = glsup_pkg::GLSUP_UNLOCKED;
        else if (gate_ok)
          state_nxt = glsup_pkg::GLSUP_LOCKED;
      glsup_pkg::GLSUP_FAULT:
        if (fault_clear && !unlock_s)
          state_nxt = glsup_pkg::GLSUP_LOCKED;
      // Unused codes of the state word fall into the safe fault state
      default:
        state_nxt = glsup_pkg::GLSUP_FAULT;
    endcase
    if (fbk_timeout || (mismatch && state_r != glsup_pkg::GLSUP_FAULT))
      state_nxt = glsup_pkg::GLSUP_FAULT;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= glsup_pkg::GLSUP_LOCKED;
    else
      state_r <= state_nxt;
  end

  // Release delay counted in ms ticks while waiting
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rel_cnt_r <= '0;
    else if (state_r != glsup_pkg::GLSUP_WAIT_RELEASE)
      rel_cnt_r <= '0;
    else if (tick && rel_cnt_r != '1)
      rel_cnt_r <= rel_cnt_r + TW'(1);
  end

  // Energise command; fault leaves the magnet as last commanded so the guard stays put
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      energise_r      <= 1'b0;
      energise_prev_r <= 1'b0;
    end
    else
    begin
      energise_prev_r <= energise_r;
      if (state_nxt == glsup_pkg::GLSUP_UNLOCKED || state_nxt == glsup_pkg::GLSUP_WAIT_CLOSE)
        energise_r <= spring_interlock;
      else if (state_nxt != glsup_pkg::GLSUP_FAULT)
        energise_r <= !spring_interlock;
    end
  end

  // Drive level follows the energise command only
  assign magnet_drive = energise_r;

  // Feedback watchdog restarts on every drive change
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fbk_pending_r <= 1'b0;
      fbk_cnt_r     <= '0;
    end
    else if (energise_r != energise_prev_r)
    begin
      fbk_pending_r <= 1'b1;
      fbk_cnt_r     <= '0;
    end
    else if (fbk_pending_r && energised == energise_r)
      fbk_pending_r <= 1'b0;
    else if (fbk_pending_r && tick && fbk_cnt_r != '1)
      fbk_cnt_r <= fbk_cnt_r + TW'(1);
  end

  // Error level held while in the fault state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      error_r <= 1'b0;
    else
      error_r <= (state_nxt == glsup_pkg::GLSUP_FAULT);
  end

  // Locked means the feedback shows the locking level settled
  assign locked_status = (state_r == glsup_pkg::GLSUP_LOCKED) && !fbk_pending_r
                       && (energised == !spring_interlock);

  // Safe output registered; unlock request clears it combinationally upstream of the flop
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      safe_out   <= 1'b0;
      fault_flag <= 1'b0;
    end
    else
    begin
      safe_out   <= locked_status && gate_ok && !unlock_s
                 && (state_nxt != glsup_pkg::GLSUP_FAULT);
      fault_flag <= fault_enable && (state_nxt == glsup_pkg::GLSUP_FAULT);
    end
  end

  // Instance count limit is a system constraint, recorded here
  localparam int unsigned INST_LIMIT = glsup_pkg::MAX_INST_LARGE;

endmodule : glsup_top

// ==== testbench/glsup_magnet_model.sv ====
// Electromagnet model whose feedback contacts lag the coil
`timescale 1ns/1ps
module glsup_magnet_model (
  input  wire logic clk,
  input  wire logic magnet_drive,
  input  wire logic stuck,
  output logic      magnet_fbk
);
  logic [3:0] lag_r = 4'h0;
  logic       fbk_r = 1'b0;
  assign magnet_fbk = fbk_r;
  // Contacts settle some cycles after the coil; stuck models a dead coil
  always @(posedge clk)
  begin
    lag_r <= (magnet_drive == fbk_r) ? 4'h0 : lag_r + 4'h1;
    if (!stuck && lag_r == 4'h5) fbk_r <= magnet_drive;
  end
endmodule : glsup_magnet_model

// ==== testbench/glsup_top_asserts.sv ====
// Port checker for the guard lock supervisor
`timescale 1ns/1ps
module glsup_top_asserts #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                         clk,
  input wire logic                         rst_b,
  input wire logic                         unlock_req,
  input wire logic                         magnet_fbk,
  input wire logic                         gate_absent,
  input wire logic                         spring_interlock,
  input wire logic                         fault_enable,
  input wire logic                         fault_clear,
  input wire logic [glsup_pkg::TIME_W-1:0] fbk_timeout_ms,
  input wire logic                         safe_out,
  input wire logic                         magnet_drive,
  input wire logic                         fault_flag,
  input wire logic                         locked_status
);
  logic [31:0] lag_r;
  // Cycles the feedback has lagged the drive; a raised fault flag clears it to zero, as the drive is frozen then
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) lag_r <= 32'h0;
    else lag_r <= (magnet_fbk != magnet_drive && !fault_flag) ? lag_r + 32'h1 : 32'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_drop_on_unlock: assert property ($rose(unlock_req) |-> ##[3:4] !safe_out) else $error("safe output kept");
  a_safe_when_locked: assert property (safe_out |-> locked_status) else $error("safe while not locked");
  a_fault_forces_low: assert property (fault_flag |-> !safe_out) else $error("safe during fault");
  a_fault_holds: assert property (fault_enable && fault_flag && !fault_clear && !$past(fault_clear)
    && !$past(fault_clear, 2)
    && !$past(fault_clear, 3) |=> fault_flag) else $error("fault dropped without clear");
  a_drive_frozen: assert property (fault_flag && !fault_clear && !$past(fault_clear) && !$past(fault_clear, 2)
    && !$past(fault_clear, 3) |=> $stable(magnet_drive)) else $error("drive moved in fault");
  a_lock_polarity: assert property (locked_status |-> magnet_drive == !spring_interlock) else $error("bad drive");
  a_fbk_timeout: assert property (lag_r <= fbk_timeout_ms * TICK_CYCLES + 3 * TICK_CYCLES + 8)
    else $error("feedback timeout missed");
  a_relock_nogate: assert property ($fell(unlock_req) && gate_absent && !fault_flag && magnet_drive == spring_interlock
    && magnet_fbk == magnet_drive |-> ##[3:5] magnet_drive != spring_interlock) else $error("relock late");
endmodule : glsup_top_asserts
bind glsup_top glsup_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_asserts (
  .clk(clk), .rst_b(rst_b), .unlock_req(unlock_req), .magnet_fbk(magnet_fbk), .gate_absent(gate_absent),
  .spring_interlock(spring_interlock), .fault_enable(fault_enable), .fault_clear(fault_clear),
  .fbk_timeout_ms(fbk_timeout_ms),
  .safe_out(safe_out), .magnet_drive(magnet_drive), .fault_flag(fault_flag), .locked_status(locked_status));

// ==== testbench/testbench.sv ====
// Self-checking bench for the guard lock supervisor
`timescale 1ns/1ps
module testbench;
  logic                         clk = 1'b0, rst_b = 1'b0, unlock_req = 1'b0, fault_clear = 1'b0, stuck = 1'b0;
  logic                         gate_closed = 1'b1, gate_absent = 1'b1;
  logic                         spring_interlock = 1'b1, fault_enable = 1'b1;
  logic [glsup_pkg::TIME_W-1:0] release_ms = 16'h0000;
  logic                         safe_out, magnet_drive, magnet_fbk, fault_flag, locked_status;
  int                           err_count = 0, comparisons = 0;
  // Short ticks keep the run small; timeout of three ticks
  glsup_top #(.TICK_CYCLES(4)) i_dut (.clk(clk), .rst_b(rst_b), .unlock_req(unlock_req), .magnet_fbk(magnet_fbk),
    .gate_closed(gate_closed), .gate_absent(gate_absent), .spring_interlock(spring_interlock),
    .fault_enable(fault_enable),
    .fault_clear(fault_clear), .release_ms(release_ms), .fbk_timeout_ms(16'h0003), .safe_out(safe_out),
    .magnet_drive(magnet_drive), .fault_flag(fault_flag), .locked_status(locked_status));
  glsup_magnet_model i_magnet (.clk(clk), .magnet_drive(magnet_drive), .stuck(stuck), .magnet_fbk(magnet_fbk));
  always #50 clk = ~clk;
  task automatic check(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Inputs only move at the falling edge
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic test_done;
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic walk_nogate;
    check(safe_out, 1'b1);
    unlock_req = 1'b1;
    settle(4);
    check(safe_out, 1'b0);
    settle(20);
    check(magnet_drive, 1'b1);
    check(fault_flag, 1'b0);
    unlock_req = 1'b0;
    settle(4);
    check(magnet_drive, 1'b0);
    settle(20);
    check(safe_out, 1'b1);
  endtask : walk_nogate
  // Two ticks of delay must still hold the lock after six cycles
  task automatic release_delay;
    release_ms = 16'h0002;
    unlock_req = 1'b1;
    settle(6);
    check(magnet_drive, 1'b0);
    settle(20);
    check(magnet_drive, 1'b1);
    unlock_req = 1'b0;
    settle(30);
  endtask : release_delay
  task automatic fbk_timeout;
    stuck = 1'b1;
    unlock_req = 1'b1;
    settle(40);
    check(fault_flag, 1'b1);
    unlock_req = 1'b0;
    settle(10);
    check(magnet_drive, 1'b1);
    stuck = 1'b0;
    // Clear only once the contacts have caught up, or the watchdog keeps the fault
    settle(30);
    fault_clear = 1'b1;
    settle(4);
    fault_clear = 1'b0;
    settle(40);
    check(fault_flag, 1'b0);
  endtask : fbk_timeout
  // Door left open after release keeps the lock off; opening it when locked is a fault
  task automatic gate_mode;
    gate_absent = 1'b0;
    unlock_req = 1'b1;
    settle(30);
    gate_closed = 1'b0;
    unlock_req = 1'b0;
    settle(20);
    check(magnet_drive, 1'b1);
    gate_closed = 1'b1;
    settle(30);
    check(safe_out, 1'b1);
    gate_closed = 1'b0;
    settle(10);
    check(fault_flag, 1'b1);
    fault_enable = 1'b0;
    settle(2);
    check(fault_flag, 1'b0);
    check(safe_out, 1'b0);
  endtask : gate_mode
  // Mid-run reset with the other lock type, where a high drive locks
  task automatic spring_low;
    rst_b = 1'b0;
    fault_enable = 1'b1;
    gate_absent = 1'b1;
    gate_closed = 1'b1;
    spring_interlock = 1'b0;
    settle(5);
    rst_b = 1'b1;
    settle(1);
    check(magnet_drive, 1'b1);
    check(safe_out, 1'b0);
    settle(30);
    check(locked_status, 1'b1);
    check(safe_out, 1'b1);
    unlock_req = 1'b1;
    settle(30);
    check(magnet_drive, 1'b0);
    check(fault_flag, 1'b0);
    unlock_req = 1'b0;
    settle(30);
    check(magnet_drive, 1'b1);
    check(safe_out, 1'b1);
  endtask : spring_low
  initial
  begin
    settle(5);
    rst_b = 1'b1;
    settle(30);
    walk_nogate();
    release_delay();
    fbk_timeout();
    gate_mode();
    spring_low();
    test_done();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule : testbench
